// ==== src/irq_pm_regs.svh ====
`ifndef IRQ_PM_REGS_SVH
`define IRQ_PM_REGS_SVH

// register addresses
`define ADDR_POWER_CONTROL          8'h87
`define ADDR_SECONDARY_IRQ_ENABLE   8'hA7
`define ADDR_PRIMARY_IRQ_ENABLE     8'hA8
`define ADDR_SECONDARY_IRQ_PRIORITY 8'hB7
`define ADDR_PRIMARY_IRQ_PRIORITY   8'hB8

// reset values
`define RST_POWER_CONTROL          8'h00
`define RST_SECONDARY_IRQ_ENABLE   8'h00
`define RST_PRIMARY_IRQ_ENABLE     8'h00
`define RST_SECONDARY_IRQ_PRIORITY 8'h00
`define RST_PRIMARY_IRQ_PRIORITY   8'h00

// writable bit masks
`define MASK_POWER_CONTROL   8'hFF
`define MASK_SECONDARY       8'h12
`define MASK_PRIMARY_ENABLE  8'hBF
`define MASK_PRIMARY_PRIO    8'h3F

// power_control fields
`define BIT_SERIAL1_BAUD_DOUBLE       7
`define BIT_SERIAL2_BAUD_DOUBLE       6
`define BIT_LOW_VOLTAGE_RESET_DISABLE 5
`define BIT_CONVERTER_IRQ_ENABLE      4
`define BIT_SERIAL2_RX_CLOCK_SELECT   3
`define BIT_SERIAL2_TX_CLOCK_SELECT   2
`define BIT_POWER_DOWN_REQUEST        1
`define BIT_IDLE_REQUEST              0

// primary enable / priority fields
`define BIT_GLOBAL_IRQ_ENABLE 7
`define BIT_TIMER2            5
`define BIT_SERIAL1           4
`define BIT_TIMER1            3
`define BIT_EXT1              2
`define BIT_TIMER0            1
`define BIT_EXT0              0

// secondary enable / priority fields
`define BIT_SERIAL2  4
`define BIT_TWOWIRE  1

// vectors
`define VEC_EXT0    16'h0003
`define VEC_TIMER0  16'h000B
`define VEC_EXT1    16'h0013
`define VEC_TIMER1  16'h001B
`define VEC_SERIAL1 16'h0023
`define VEC_TIMER2  16'h002B
`define VEC_TWOWIRE 16'h0043
`define VEC_SERIAL2 16'h004B

// machine cycles an internal reset is held
`define INT_RESET_MCYCLES 2'h3

`endif

// ==== src/irq_pm_pkg.sv ====
`default_nettype none
package irq_pm_pkg;

	// source index = polling order, 0 polled first
	typedef enum logic [2:0] {
		src_ext0, src_serial2, src_timer0, src_twowire,
		src_ext1, src_timer1, src_serial1, src_timer2
	} src_t;

	typedef enum logic [1:0] {
		mode_run, mode_idle, mode_power_down
	} mode_t;

	typedef struct packed {
		logic [7:0]  power_control;
		logic [7:0]  primary_irq_enable;
		logic [7:0]  secondary_irq_enable;
		logic [7:0]  primary_irq_priority;
		logic [7:0]  secondary_irq_priority;
		logic [7:0]  rdata;
		logic [7:0]  sample;
		logic        reg_touch;
		logic        hi_in_progress;
		logic        lo_in_progress;
		logic        call_req;
		logic [15:0] call_vector;
		logic [7:0]  call_ack;
		mode_t       mode;
		logic        rst_active;
		logic [1:0]  rst_cnt;
	} state_t;

endpackage : irq_pm_pkg
`default_nettype wire

// ==== src/interrupt_and_power_mode_ctrl.sv ====
// Summary of operation
// - sample flags at S5P2, poll next cycle
// - unblocked set flag forces long call
// - block while equal or higher level active
// - call only in instruction's last cycle
// - block on return or enable/priority access
// - blocked requests are never remembered
// - call pushes program counter, loads vector
// - fixed vector address per source
// - interrupt return clears current level
// - plain return keeps in-progress state
// - idle bit halts cpu after instruction
// - core state held while idle
// - enabled interrupt clears idle and serviced
// - internal reset restarts after 3 cycles
// - power-down bit stops oscillator after instruction
// - only reset leaves power-down
// - low-voltage detect works in power-down
// - power control layout, reset 00
// - secondary enable: serial2 bit4, twowire bit1
// - primary priority bits 5..0
// - secondary priority: serial2 bit4, twowire bit1
// - high level preempts low, never preempted
// - fixed polling order within a level
// - global enable gates all interrupts
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "irq_pm_regs.svh"

module interrupt_and_power_mode_ctrl
	import irq_pm_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// core sequencer
	input  wire logic        phase_s5p2,
	input  wire logic        last_cycle,
	input  wire logic        instr_return_from_interrupt,
	input  wire logic        return_from_interrupt_done,
	output logic             call_req,
	output logic      [15:0] call_vector,
	output logic             push_pc,
	output logic             cpu_halt,
	// interrupt sources, polling order
	input  wire logic [7:0]  irq_flags,
	output logic      [7:0]  irq_ack,
	// power and reset
	input  wire logic        low_voltage_detect,
	input  wire logic        watchdog_reset,
	output logic             osc_stop,
	output logic             internal_reset,
	// power_control fields to peripherals
	output logic             serial1_baud_double,
	output logic             serial2_baud_double,
	output logic             converter_irq_enable,
	output logic             serial2_rx_clock_select,
	output logic             serial2_tx_clock_select
);

	////////////////////////////////////////////////////////////////////////
	// functions

	function automatic logic [15:0] vector_of(input logic [2:0] s);
		case (src_t'(s))
			src_ext0:    vector_of = `VEC_EXT0;
			src_serial2: vector_of = `VEC_SERIAL2;
			src_timer0:  vector_of = `VEC_TIMER0;
			src_twowire: vector_of = `VEC_TWOWIRE;
			src_ext1:    vector_of = `VEC_EXT1;
			src_timer1:  vector_of = `VEC_TIMER1;
			src_serial1: vector_of = `VEC_SERIAL1;
			src_timer2:  vector_of = `VEC_TIMER2;
			default:     vector_of = `VEC_EXT0;
		endcase
	endfunction : vector_of

	// map primary / secondary register bits into polling order
	function automatic logic [7:0] by_order(input logic [7:0] p,
			input logic [7:0] s);
		by_order = {p[`BIT_TIMER2], p[`BIT_SERIAL1], p[`BIT_TIMER1],
			p[`BIT_EXT1], s[`BIT_TWOWIRE], p[`BIT_TIMER0],
			s[`BIT_SERIAL2], p[`BIT_EXT0]};
	endfunction : by_order

	// lowest index set wins
	function automatic logic [2:0] first_set(input logic [7:0] v);
		first_set = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				first_set = i[2:0];
			end
		end
	endfunction : first_set

	////////////////////////////////////////////////////////////////////////
	// state

	state_t q;
	state_t d;

	logic [7:0] enabled;
	logic [7:0] pending;
	logic [7:0] pend_hi;
	logic [7:0] pend_lo;
	logic [7:0] prio;
	logic       block_cycle;
	logic       take_hi;
	logic       take_lo;
	logic [2:0] pick;
	logic       reset_trigger;
	logic       wr_idle;

	always_comb begin
		d = q;
		// one-cycle outputs
		d.call_req = 1'b0;
		d.call_ack = 8'h00;
		d.rdata = 8'h00;

		// register reads, reserved bits zero
		if (reg_rd) begin
			case (reg_addr)
				`ADDR_POWER_CONTROL:          d.rdata = q.power_control;
				`ADDR_PRIMARY_IRQ_ENABLE:     d.rdata = q.primary_irq_enable;
				`ADDR_SECONDARY_IRQ_ENABLE:   d.rdata = q.secondary_irq_enable;
				`ADDR_PRIMARY_IRQ_PRIORITY:   d.rdata = q.primary_irq_priority;
				`ADDR_SECONDARY_IRQ_PRIORITY: d.rdata = q.secondary_irq_priority;
				default:                      d.rdata = 8'h00;
			endcase
		end

		// enable/priority access during this machine cycle
		if ((reg_rd || reg_wr) && reg_addr != `ADDR_POWER_CONTROL &&
				(reg_addr == `ADDR_PRIMARY_IRQ_ENABLE ||
				reg_addr == `ADDR_SECONDARY_IRQ_ENABLE ||
				reg_addr == `ADDR_PRIMARY_IRQ_PRIORITY ||
				reg_addr == `ADDR_SECONDARY_IRQ_PRIORITY)) begin
			d.reg_touch = 1'b1;
		end

		// polling: enables and levels
		enabled = by_order(q.primary_irq_enable, q.secondary_irq_enable);
		enabled = enabled & {8{q.primary_irq_enable[`BIT_GLOBAL_IRQ_ENABLE]}};
		prio = by_order(q.primary_irq_priority, q.secondary_irq_priority);
		pending = q.sample & enabled;
		pend_hi = pending & prio;
		pend_lo = pending & ~prio;
		block_cycle = !last_cycle || instr_return_from_interrupt || q.reg_touch
			|| d.reg_touch;
		take_hi = (pend_hi != 8'h00) && !q.hi_in_progress;
		take_lo = (pend_lo != 8'h00) && !q.hi_in_progress
			&& !q.lo_in_progress;
		pick = take_hi ? first_set(pend_hi) : first_set(pend_lo);

		// interrupt return clears the current level only; a call wins
		if (return_from_interrupt_done) begin
			if (q.hi_in_progress) begin
				d.hi_in_progress = 1'b0;
			end else begin
				d.lo_in_progress = 1'b0;
			end
		end

		if (phase_s5p2 && q.mode != mode_power_down) begin
			if (!block_cycle && (take_hi || take_lo)) begin
				d.call_req = 1'b1;
				d.call_vector = vector_of(pick);
				d.call_ack[pick] = 1'b1;
				if (take_hi) begin
					d.hi_in_progress = 1'b1;
				end else begin
					d.lo_in_progress = 1'b1;
				end
			end
			// fresh samples every machine cycle
			d.sample = irq_flags;
			d.reg_touch = 1'b0;
		end

		// idle: any enabled request wakes, hardware clears idle bit
		if (q.mode == mode_idle && pending != 8'h00) begin
			d.power_control[`BIT_IDLE_REQUEST] = 1'b0;
			d.mode = mode_run;
		end

		// register writes; a software set wins over the wake clear
		wr_idle = 1'b0;
		if (reg_wr && q.mode != mode_power_down) begin
			case (reg_addr)
				`ADDR_POWER_CONTROL: begin
					d.power_control = reg_wdata & `MASK_POWER_CONTROL;
					wr_idle = reg_wdata[`BIT_IDLE_REQUEST];
				end
				`ADDR_PRIMARY_IRQ_ENABLE:
					d.primary_irq_enable = reg_wdata & `MASK_PRIMARY_ENABLE;
				`ADDR_SECONDARY_IRQ_ENABLE:
					d.secondary_irq_enable = reg_wdata & `MASK_SECONDARY;
				`ADDR_PRIMARY_IRQ_PRIORITY:
					d.primary_irq_priority = reg_wdata & `MASK_PRIMARY_PRIO;
				`ADDR_SECONDARY_IRQ_PRIORITY:
					d.secondary_irq_priority = reg_wdata & `MASK_SECONDARY;
				default: ;
			endcase
		end
		if (wr_idle) begin
			d.power_control[`BIT_IDLE_REQUEST] = 1'b1;
		end

		// mode entry at the end of the instruction that set the bit
		if (phase_s5p2 && last_cycle && q.mode == mode_run) begin
			if (q.power_control[`BIT_POWER_DOWN_REQUEST]) begin
				d.mode = mode_power_down;
			end else if (q.power_control[`BIT_IDLE_REQUEST]
					&& pending == 8'h00) begin
				d.mode = mode_idle;
			end
		end

		// internal reset: hold for a fixed count of machine cycles
		reset_trigger = watchdog_reset || (low_voltage_detect &&
			!q.power_control[`BIT_LOW_VOLTAGE_RESET_DISABLE]);
		if (reset_trigger) begin
			d = '0;
			d.mode = mode_run;
			d.rst_active = 1'b1;
			d.rst_cnt = `INT_RESET_MCYCLES;
		end else if (q.rst_active) begin
			// registers stay at reset values until release
			d = q;
			d.call_req = 1'b0;
			d.call_ack = 8'h00;
			d.rdata = 8'h00;
			if (phase_s5p2) begin
				d.rst_cnt = q.rst_cnt - 2'h1;
				if (q.rst_cnt == 2'h1) begin
					d.rst_active = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			// external reset, held by the system for two machine cycles
			q                        <= '0;
			q.power_control          <= `RST_POWER_CONTROL;
			q.primary_irq_enable     <= `RST_PRIMARY_IRQ_ENABLE;
			q.secondary_irq_enable   <= `RST_SECONDARY_IRQ_ENABLE;
			q.primary_irq_priority   <= `RST_PRIMARY_IRQ_PRIORITY;
			q.secondary_irq_priority <= `RST_SECONDARY_IRQ_PRIORITY;
			q.mode                   <= mode_run;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign reg_rdata   = q.rdata;
	assign call_req    = q.call_req;
	assign call_vector = q.call_vector;
	// core pushes the program counter only, not the status word
	assign push_pc     = q.call_req;
	assign irq_ack     = q.call_ack;
	assign cpu_halt    = (q.mode != mode_run);
	assign osc_stop    = (q.mode == mode_power_down);
	// combinational path so detection acts with the clock stopped
	assign internal_reset = q.rst_active || reset_trigger;

	assign serial1_baud_double     = q.power_control[`BIT_SERIAL1_BAUD_DOUBLE];
	assign serial2_baud_double     = q.power_control[`BIT_SERIAL2_BAUD_DOUBLE];
	assign converter_irq_enable    = q.power_control[`BIT_CONVERTER_IRQ_ENABLE];
	assign serial2_rx_clock_select =
		q.power_control[`BIT_SERIAL2_RX_CLOCK_SELECT];
	assign serial2_tx_clock_select =
		q.power_control[`BIT_SERIAL2_TX_CLOCK_SELECT];

endmodule : interrupt_and_power_mode_ctrl

`default_nettype wire

// ==== tb/irq_pm_ctrl_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module irq_pm_sva (
	// clock and reset
	input wire logic        clk,
	input wire logic        reset_n,
	// core sequencer
	input wire logic        phase_s5p2,
	input wire logic        last_cycle,
	input wire logic        instr_return_from_interrupt,
	input wire logic        call_req,
	input wire logic        push_pc,
	input wire logic [15:0] call_vector,
	input wire logic [7:0]  irq_ack,
	input wire logic        cpu_halt,
	// power and reset
	input wire logic        low_voltage_detect,
	input wire logic        watchdog_reset,
	input wire logic        osc_stop,
	input wire logic        internal_reset
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////
	property p_push; call_req |-> push_pc && $onehot(irq_ack); endproperty
	a_push: assert property (p_push) else $error("call without push");
	property p_last; call_req |-> $past(phase_s5p2 && last_cycle); endproperty
	a_last: assert property (p_last) else $error("call off last cycle");
	property p_return_from_interrupt; call_req |-> !$past(instr_return_from_interrupt); endproperty
	a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("call during return");
	property p_vec; call_req && irq_ack[3] |-> call_vector == 16'h0043; endproperty
	a_vec: assert property (p_vec) else $error("bad two-wire vector");
	property p_one; call_req |=> !call_req; endproperty
	a_one: assert property (p_one) else $error("call longer than a pulse");
	property p_halt; $rose(cpu_halt) |-> $past(phase_s5p2 && last_cycle); endproperty
	a_halt: assert property (p_halt) else $error("halt mid instruction");
	property p_pdcall; osc_stop && $past(osc_stop) |-> !call_req && cpu_halt;
	endproperty
	a_pdcall: assert property (p_pdcall) else $error("call in power-down");
	property p_pdkeep;
		osc_stop && !watchdog_reset && !low_voltage_detect |=> osc_stop;
	endproperty
	a_pdkeep: assert property (p_pdkeep) else $error("power-down left");
	property p_wd; watchdog_reset |-> internal_reset; endproperty
	a_wd: assert property (p_wd) else $error("no internal reset");
	c_call: cover property (call_req);
	c_idle: cover property ($rose(cpu_halt) && !osc_stop);
	c_pd: cover property (osc_stop);
	c_irst: cover property (internal_reset);
endmodule : irq_pm_sva
bind interrupt_and_power_mode_ctrl irq_pm_sva chk_u (.clk(clk),
	.reset_n(reset_n), .phase_s5p2(phase_s5p2), .last_cycle(last_cycle),
	.instr_return_from_interrupt(instr_return_from_interrupt), .call_req(call_req), .push_pc(push_pc),
	.call_vector(call_vector), .irq_ack(irq_ack), .cpu_halt(cpu_halt),
	.low_voltage_detect(low_voltage_detect), .osc_stop(osc_stop),
	.watchdog_reset(watchdog_reset), .internal_reset(internal_reset));
`default_nettype wire

// ==== tb/core_seq_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module core_seq_model (
	// clock and reset
	input wire logic       clk,
	input wire logic       reset_n,
	// instruction length in machine cycles
	input wire logic [1:0] instr_len,
	input wire logic       osc_stop,
	// machine cycle timing
	output logic           phase_s5p2,
	output logic           last_cycle
);
	logic [1:0] ph_q;
	logic [1:0] mc_q;
	// four clocks a machine cycle; no timing while the oscillator is off
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ph_q <= 2'h0;
			mc_q <= 2'h0;
		end else if (!osc_stop) begin
			ph_q <= ph_q + 2'h1;
			if (ph_q == 2'h3)
				mc_q <= (mc_q + 2'h1 >= instr_len) ? 2'h0 : mc_q + 2'h1;
		end
	end
	assign phase_s5p2 = (ph_q == 2'h2) && !osc_stop;
	assign last_cycle = (mc_q == instr_len - 2'h1);
endmodule : core_seq_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import irq_pm_pkg::*;
	logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, irq_flags = 8'h00;
	logic instr_return_from_interrupt = 1'b0, return_from_interrupt_done = 1'b0, watchdog_reset = 1'b0;
	logic low_voltage_detect = 1'b0;
	logic [1:0] instr_len = 2'h1;
	logic [7:0] reg_rdata, irq_ack;
	logic [15:0] call_vector;
	logic phase_s5p2, last_cycle, call_req, push_pc, cpu_halt, osc_stop;
	logic internal_reset, s1bd, s2bd, cie, s2rx, s2tx;
	int n_errors = 0, compares = 0;
	always #50 clk = ~clk;
	core_seq_model seq_u (.clk(clk), .reset_n(reset_n), .instr_len(instr_len),
		.osc_stop(osc_stop), .phase_s5p2(phase_s5p2), .last_cycle(last_cycle));
	interrupt_and_power_mode_ctrl dut_u (.clk(clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .phase_s5p2(phase_s5p2),
		.last_cycle(last_cycle), .instr_return_from_interrupt(instr_return_from_interrupt), .return_from_interrupt_done(return_from_interrupt_done),
		.call_req(call_req), .call_vector(call_vector), .push_pc(push_pc),
		.cpu_halt(cpu_halt), .irq_flags(irq_flags), .irq_ack(irq_ack),
		.low_voltage_detect(low_voltage_detect), .osc_stop(osc_stop),
		.watchdog_reset(watchdog_reset), .internal_reset(internal_reset),
		.serial1_baud_double(s1bd), .serial2_baud_double(s2bd),
		.converter_irq_enable(cie), .serial2_rx_clock_select(s2rx),
		.serial2_tx_clock_select(s2tx));
	////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) begin
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
		end
		@(posedge clk) reg_wr <= 1'b0;
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk) begin
			reg_addr <= a;
			reg_rd <= 1'b1;
		end
		@(posedge clk) reg_rd <= 1'b0;
		@(posedge clk) chk(16'(reg_rdata), 16'(exp));
	endtask : rdc
	task automatic wait_call(input logic [7:0] ack, input logic [15:0] vec);
		int i;
		for (i = 0; i < 300 && call_req !== 1'b1; i++)
			@(posedge clk);
		if (i == 300) begin
			n_errors++;
			$display("Error at %0t: no call", $time);
			test_done();
		end else begin
			chk(16'(irq_ack), 16'(ack));
			chk(call_vector, vec);
		end
	endtask : wait_call
	task automatic no_call(input int n);
		int k;
		k = 0;
		repeat (n) begin
			@(posedge clk);
			if (call_req !== 1'b0)
				k++;
		end
		chk(16'(k), 16'h0);
	endtask : no_call
	task automatic ret;
		cyc(10);
		@(posedge clk) return_from_interrupt_done <= 1'b1;
		@(posedge clk) return_from_interrupt_done <= 1'b0;
	endtask : ret
	////////////////////////////////////////////////////////////////
	task automatic t_regs;
		logic [7:0] a [5] = '{8'h87, 8'hA7, 8'hA8, 8'hB7, 8'hB8};
		logic [7:0] e [5] = '{8'hFC, 8'h12, 8'hBF, 8'h12, 8'h3F};
		for (int i = 0; i < 5; i++) begin
			rdc(a[i], 8'h00);
			wr(a[i], (i == 0) ? 8'hFC : 8'hFF);
			rdc(a[i], e[i]);
		end
		chk(16'({s1bd, s2bd, cie, s2rx, s2tx}), 16'h001F);
		rdc(8'h55, 8'h00);
		for (int i = 0; i < 5; i++)
			wr(a[i], 8'h00);
	endtask : t_regs
	task automatic t_vec;
		logic [15:0] v [8] = '{16'h0003, 16'h004B, 16'h000B, 16'h0043,
			16'h0013, 16'h001B, 16'h0023, 16'h002B};
		wr(8'hA8, 8'hBF);
		wr(8'hA7, 8'h12);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk) irq_flags <= 8'h01 << i;
			wait_call(8'h01 << i, v[i]);
			irq_flags <= 8'h00;
			ret();
		end
	endtask : t_vec
	task automatic t_prio;
		wr(8'hB8, 8'h20);
		@(posedge clk) irq_flags <= 8'h7F;
		wait_call(8'h01, 16'h0003);
		irq_flags <= 8'h7E;
		no_call(40);
		irq_flags <= 8'hFE;
		wait_call(8'h80, 16'h002B);
		no_call(40);
		irq_flags <= 8'h7E;
		ret();
		no_call(40);
		ret();
		wait_call(8'h02, 16'h004B);
		irq_flags <= 8'h00;
		ret();
		wr(8'hB8, 8'h00);
	endtask : t_prio
	task automatic t_block;
		@(posedge clk) begin
			instr_len <= 2'h3;
			irq_flags <= 8'h04;
			instr_return_from_interrupt <= 1'b1;
		end
		no_call(40);
		irq_flags <= 8'h00;
		no_call(12);
		instr_return_from_interrupt <= 1'b0;
		no_call(40);
		irq_flags <= 8'h04;
		wait_call(8'h04, 16'h000B);
		irq_flags <= 8'h00;
		ret();
		wr(8'hA8, 8'h3F);
		@(posedge clk) irq_flags <= 8'h04;
		no_call(40);
		irq_flags <= 8'h00;
		instr_len <= 2'h1;
		wr(8'hA8, 8'hBF);
	endtask : t_block
	task automatic t_idle;
		wr(8'h87, 8'h01);
		cyc(8);
		chk(16'(cpu_halt), 16'h1);
		rdc(8'hA8, 8'hBF);
		irq_flags <= 8'h04;
		wait_call(8'h04, 16'h000B);
		chk(16'(cpu_halt), 16'h0);
		irq_flags <= 8'h00;
		rdc(8'h87, 8'h00);
		ret();
	endtask : t_idle
	task automatic t_wd;
		int i;
		@(posedge clk) watchdog_reset <= 1'b1;
		@(posedge clk) watchdog_reset <= 1'b0;
		cyc(7);
		chk(16'(internal_reset), 16'h1);
		for (i = 0; i < 12 && internal_reset !== 1'b0; i++)
			@(posedge clk);
		chk(16'(i < 12), 16'h1);
		rdc(8'hA8, 8'h00);
	endtask : t_wd
	task automatic t_pd;
		wr(8'h87, 8'h20);
		@(posedge clk) low_voltage_detect <= 1'b1;
		cyc(2);
		chk(16'(internal_reset), 16'h0);
		low_voltage_detect <= 1'b0;
		wr(8'hA8, 8'hBF);
		wr(8'h87, 8'h02);
		cyc(8);
		chk(16'({osc_stop, cpu_halt}), 16'h3);
		@(posedge clk) irq_flags <= 8'h01;
		no_call(40);
		chk(16'(osc_stop), 16'h1);
		wr(8'h87, 8'h00);
		rdc(8'h87, 8'h02);
		@(posedge clk) low_voltage_detect <= 1'b1;
		@(negedge clk) chk(16'(internal_reset), 16'h1);
		@(posedge clk) begin
			low_voltage_detect <= 1'b0;
			irq_flags <= 8'h00;
		end
		cyc(16);
		chk(16'(osc_stop), 16'h0);
		wr(8'h87, 8'h02);
		cyc(8);
		chk(16'(osc_stop), 16'h1);
		@(posedge clk) reset_n <= 1'b0;
		cyc(8);
		reset_n <= 1'b1;
		cyc(2);
		chk(16'(osc_stop), 16'h0);
		rdc(8'h87, 8'h00);
	endtask : t_pd
	////////////////////////////////////////////////////////////////
	initial begin
		cyc(4);
		reset_n <= 1'b1;
		t_regs();
		t_vec();
		t_prio();
		t_block();
		t_idle();
		t_wd();
		t_pd();
		test_done();
	end
endmodule : tb_top
`default_nettype wire
